// ==== src/ibsrl_loader.sv ====
// Boot start selection, clock mode and serial record loader
//
// Behaviour
// - User flash in 4K blocks; old 8K and 16K block codes still accepted.
// - Status byte and boot vector share one block, erased together.
// - Security block holds lock bits and clock bit; only chip erase clears it.
// - Three lock bits block parallel reads or writes; serial access is software's.
// - Flash clock-mode bit is sampled only at reset release.
// - Enabled boot ROM overlays FC00 to FFFF; disabled shows user flash.
// - Machine cycle 6 clocks if flash bit set, else register bit decides 6/12.
// - Chip erase clears the flash clock-mode bit so the register bit rules.
// - Zero status starts at 0000H, else at boot vector high byte, low 00H; the code starts an erased 0FFH vector at 0FC00H.
// - Factory boot vector is 0FCH, starting the loader at 0FC00H.
// - Strobe low, access pin high, latch pin high at reset forces loader start.
// - First character U sets the bit time for the serial link.
// - Every received character is echoed back.
// - Only colon records with count, address, type, data, checksum, CRLF.
// - A record carries at most 16 data bytes.
// - Type 00 is data to program, 01 end of file, others commands.
// - Record stored and summed while arriving; acted on after the end.
// - Checksum mismatch sends X and skips the operation.
// - Executed record answers with a period.
// - Data record answers period only if every byte programmed.
// - A failed byte answers R instead.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module ibsrl_loader (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             rxd,
   output logic                  txd,
   input  wire logic             program_store_strobe_n,
   input  wire logic             external_access_pin,
   input  wire logic             addr_latch_pin,
   input  wire logic [7:0]       status_byte,
   input  wire logic [7:0]       boot_vector,
   input  wire logic             flash_clock_double_bit,
   input  wire logic [2:0]       sec_bits,
   output ibsrl_pkg::ibsrl_fl_req_t fl_req,
   input  wire logic             fl_done,
   input  wire logic             fl_ok,
   output ibsrl_pkg::ibsrl_boot_t boot,
   input  wire logic [15:0]      fetch_addr,
   output logic                  rom_sel,
   output logic [9:0]            rom_addr,
   output logic                  mc_tick,
   output logic                  par_rd_lock,
   output logic                  par_wr_lock
);
   import ibsrl_pkg::*;
   `include "ibsrl_defs.svh"

   logic [3:0]   pin_raw;
   logic [3:0]   s1;
   logic [3:0]   s2;
   logic [3:0]   s3;
   logic [3:0]   filt;
   logic [2:0]   settle;
   logic [1:0]   clock_config_register;
   logic [3:0]   mc_cnt;
   logic         rx_valid;
   logic [7:0]   rx_data;
   logic         locked;
   logic         tx_busy;
   logic         tx_go;
   logic [7:0]   tx_byte;
   logic         echo_pend;
   logic [7:0]   echo_char;
   logic         resp_pend;
   logic         reply_go;
   logic [7:0]   reply_char;
   logic [7:0]   last_reply;
   logic [7:0]   last_type;
   logic [7:0]   osc_freq;
   ibsrl_p_st_t  pst;
   logic [7:0]   rec [0:`IBSRL_REC_LEN-1];
   logic [4:0]   idx;
   logic         nib;
   logic [3:0]   hi;
   logic [7:0]   sum;
   logic         bad;
   logic [3:0]   pidx;
   logic         fail;
   logic [3:0]   blk_last;
   logic         chip;
   logic [4:0]   hv;
   logic [7:0]   byte_in;
   logic [8:0]   om;

   // Returns {valid, value} for an ASCII hex digit, either case
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      logic [7:0] d;
      d = 8'h00;
      if (c >= 8'h30 && c <= 8'h39) begin
         d = c - 8'h30;
         return {1'b1, d[3:0]};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         d = c - 8'h37;
         return {1'b1, d[3:0]};
      end else if (c >= 8'h61 && c <= 8'h66) begin
         d = c - 8'h57;
         return {1'b1, d[3:0]};
      end
      return 5'h00;
   endfunction : hex_val

   // Maps an old 8K/16K selection code to {valid, first, last} 4K blocks
   function automatic logic [8:0] old_map(input logic [7:0] ss);
      if (ss == 8'h00) return {1'b1, 4'h0, 4'h1};
      else if (ss == 8'h20) return {1'b1, 4'h2, 4'h3};
      else if (ss == 8'h40) return {1'b1, 4'h4, 4'h7};
      else if (ss == 8'h80) return {1'b1, 4'h8, 4'hB};
      else if (ss == 8'hC0) return {1'b1, 4'hC, 4'hF};
      return 9'h000;
   endfunction : old_map

   assign pin_raw = {rxd, addr_latch_pin, external_access_pin, program_store_strobe_n};
   assign hv = hex_val(rx_data);
   assign byte_in = {hi, hv[3:0]};
   assign om = old_map(rec[5]);

   // Pins settle only when the second and third stages agree
   localparam logic [3:0] pin_idle = `IBSRL_PIN_RST;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1[gi] <= pin_idle[gi];
               s2[gi] <= pin_idle[gi];
               s3[gi] <= pin_idle[gi];
               filt[gi] <= pin_idle[gi];
            end else begin
               s1[gi] <= pin_raw[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi]) filt[gi] <= s3[gi];
            end
         end
      end
   endgenerate

   // Boot decision taken once, from the filtered pins, when the settle count reaches IBSRL_SETTLE after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         settle <= 3'h0;
         boot <= '0;
         par_rd_lock <= 1'b1;
         par_wr_lock <= 1'b1;
      end else begin
         par_rd_lock <= sec_bits[1] | sec_bits[2];
         par_wr_lock <= |sec_bits;
         if (!boot.valid) begin
            if (settle != `IBSRL_SETTLE) begin
               settle <= settle + 3'h1;
            end else begin
               boot.valid <= 1'b1;
               boot.fx2 <= flash_clock_double_bit;
               boot.forced <= !filt[0] && filt[1] && filt[2];
               if (status_byte == 8'h00 && !(!filt[0] && filt[1] && filt[2]))
                  boot.start <= 16'h0000;
               else if (boot_vector == `IBSRL_ERASED)
                  boot.start <= {`IBSRL_BOOT_VEC, 8'h00};
               else
                  boot.start <= {boot_vector, 8'h00};
            end
         end
      end
   end

   // Machine cycle enable; latched flash bit overrides the register bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mc_cnt <= 4'h0;
         mc_tick <= 1'b0;
      end else begin
         mc_tick <= 1'b0;
         if ((boot.fx2 || clock_config_register[`IBSRL_CTRL_X2]) ?
             (mc_cnt >= `IBSRL_MC_FAST - 4'h1) :
             (mc_cnt >= `IBSRL_MC_SLOW - 4'h1)) begin
            mc_cnt <= 4'h0;
            mc_tick <= 1'b1;
         end else begin
            mc_cnt <= mc_cnt + 4'h1;
         end
      end
   end

   // Overlay select is one cycle behind the fetch address
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rom_sel <= 1'b0;
         rom_addr <= 10'h000;
      end else begin
         rom_sel <= clock_config_register[`IBSRL_CTRL_ROM] &&
                    fetch_addr >= `IBSRL_ROM_BASE;
         rom_addr <= fetch_addr[9:0];
      end
   end

   ibsrl_uart u_uart (
      .clk      (clk),
      .resetn   (resetn),
      .rxd      (filt[3]),
      .tx_start (tx_go),
      .tx_data  (tx_byte),
      .txd      (txd),
      .tx_busy  (tx_busy),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .locked   (locked)
   );

   // Echo goes out before any reply; a new request wins over a same-cycle clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         echo_pend <= 1'b0; echo_char <= 8'h00; resp_pend <= 1'b0;
         tx_go <= 1'b0; tx_byte <= 8'h00; last_reply <= 8'h00;
      end else begin
         tx_go <= 1'b0;
         if (!tx_busy && !tx_go) begin
            if (echo_pend) begin
               tx_go <= 1'b1;
               tx_byte <= echo_char;
               echo_pend <= 1'b0;
            end else if (resp_pend) begin
               tx_go <= 1'b1;
               tx_byte <= last_reply;
               resp_pend <= 1'b0;
            end
         end
         if (rx_valid) begin
            echo_pend <= 1'b1;
            echo_char <= rx_data;
         end
         if (reply_go) begin
            resp_pend <= 1'b1;
            last_reply <= reply_char;
         end
      end
   end

   // Record interpreter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pst <= P_IDLE; idx <= 5'h00; nib <= 1'b0; hi <= 4'h0; sum <= 8'h00;
         bad <= 1'b0; pidx <= 4'h0; fail <= 1'b0; blk_last <= 4'h0;
         chip <= 1'b0; reply_go <= 1'b0; reply_char <= 8'h00;
         last_type <= 8'h00; osc_freq <= 8'h00; fl_req <= '0;
         for (int i = 0; i < `IBSRL_REC_LEN; i++) rec[i] <= 8'h00;
      end else begin
         reply_go <= 1'b0;
         fl_req.prog <= 1'b0;
         fl_req.erase <= 1'b0;
         fl_req.chip <= 1'b0;
         case (pst)
            P_IDLE: if (rx_valid && locked && rx_data == `IBSRL_CH_COLON) begin
               idx <= 5'h00;
               nib <= 1'b0;
               sum <= 8'h00;
               bad <= 1'b0;
               pst <= P_HEX;
            end
            P_HEX: if (rx_valid) begin
               if (!hv[4]) begin
                  pst <= P_IDLE;
               end else if (!nib) begin
                  hi <= hv[3:0];
                  nib <= 1'b1;
               end else begin
                  nib <= 1'b0;
                  rec[idx] <= byte_in;
                  sum <= sum + byte_in;
                  idx <= idx + 5'h01;
                  if (idx == 5'h00 && byte_in > `IBSRL_MAX_DATA) begin
                     bad <= 1'b1;
                     pst <= P_EOL;
                  end else if (idx != 5'h00 && idx == rec[0][4:0] + 5'h04) begin
                     pst <= P_EOL;
                  end
               end
            end
            P_EOL: if (rx_valid && rx_data == `IBSRL_CH_LF) pst <= P_EXEC;
            P_EXEC: begin
               last_type <= rec[3];
               pst <= P_IDLE;
               reply_char <= `IBSRL_CH_DOT;
               reply_go <= 1'b1;
               if (bad || sum != 8'h00) begin
                  reply_char <= `IBSRL_CH_X;
               end else if (rec[3] == `IBSRL_T_DATA) begin
                  pidx <= 4'h0;
                  fail <= 1'b0;
                  if (rec[0] != 8'h00) begin
                     reply_go <= 1'b0;
                     pst <= P_PROG;
                  end
               end else if (rec[3] == `IBSRL_T_OSC) begin
                  osc_freq <= rec[4];
               end else if (rec[3] == `IBSRL_T_MISC) begin
                  if (rec[4] == `IBSRL_F_CHIP) begin
                     chip <= 1'b1;
                     reply_go <= 1'b0;
                     pst <= P_ERASE;
                  end else if (rec[4] == `IBSRL_F_BLK4K) begin
                     chip <= 1'b0;
                     fl_req.block <= rec[5][7:4];
                     blk_last <= rec[5][7:4];
                     reply_go <= 1'b0;
                     pst <= P_ERASE;
                  end else if (rec[4] == `IBSRL_F_OLD && om[8]) begin
                     chip <= 1'b0;
                     fl_req.block <= om[7:4];
                     blk_last <= om[3:0];
                     reply_go <= 1'b0;
                     pst <= P_ERASE;
                  end
               end
            end
            P_PROG: begin
               fl_req.prog <= 1'b1;
               fl_req.addr <= {rec[1], rec[2]} + {12'h000, pidx};
               fl_req.data <= rec[5'(pidx) + 5'h04];
               pst <= P_PWAIT;
            end
            P_PWAIT: if (fl_done) begin
               if (pidx == rec[0][3:0] - 4'h1 || rec[0] == `IBSRL_MAX_DATA && pidx == 4'hF) begin
                  reply_char <= (fail || !fl_ok) ? `IBSRL_CH_R : `IBSRL_CH_DOT;
                  reply_go <= 1'b1;
                  pst <= P_IDLE;
               end else begin
                  fail <= fail | !fl_ok;
                  pidx <= pidx + 4'h1;
                  pst <= P_PROG;
               end
            end
            P_ERASE: begin
               // Block numbers reach user code only; security block needs chip erase
               fl_req.erase <= !chip;
               fl_req.chip <= chip;
               pst <= P_EWAIT;
            end
            P_EWAIT: if (fl_done) begin
               if (chip || fl_req.block == blk_last) begin
                  reply_char <= `IBSRL_CH_DOT;
                  reply_go <= 1'b1;
                  pst <= P_IDLE;
               end else begin
                  fl_req.block <= fl_req.block + 4'h1;
                  pst <= P_ERASE;
               end
            end
            default: pst <= P_IDLE;
         endcase
      end
   end

   // APB slave: no wait states, unmapped addresses answer with an error
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         clock_config_register <= `IBSRL_CTRL_RST;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pready <= 1'b1;
            prdata <= 32'h00000000;
            if (paddr == `IBSRL_A_CTRL) begin
               prdata <= {30'h00000000, clock_config_register};
            end else if (paddr == `IBSRL_A_STAT) begin
               prdata <= {8'h00, sec_bits, pst != P_IDLE, locked, boot.fx2,
                          boot.forced, boot.valid, boot.start};
            end else if (paddr == `IBSRL_A_REC) begin
               prdata <= {8'h00, osc_freq, last_type, last_reply};
            end else begin
               pslverr <= 1'b1;
            end
         end
         if (psel && penable && pready && pwrite && paddr == `IBSRL_A_CTRL)
            clock_config_register <= pwdata[1:0];
      end
   end
endmodule : ibsrl_loader

// ==== src/ibsrl_defs.svh ====
// Constants for the boot select and record loader
`ifndef IBSRL_DEFS_SVH
`define IBSRL_DEFS_SVH
`define IBSRL_A_CTRL     12'h000
`define IBSRL_A_STAT     12'h004
`define IBSRL_A_REC      12'h008
`define IBSRL_CTRL_X2    0
`define IBSRL_CTRL_ROM   1
`define IBSRL_CTRL_RST   2'h2
`define IBSRL_PIN_RST    4'h9
`define IBSRL_SETTLE     3'h4
`define IBSRL_MAX_DATA   8'h10
`define IBSRL_REC_LEN    21
`define IBSRL_CH_COLON   8'h3A
`define IBSRL_CH_LF      8'h0A
`define IBSRL_CH_X       8'h58
`define IBSRL_CH_R       8'h52
`define IBSRL_CH_DOT     8'h2E
`define IBSRL_CH_U       8'h55
`define IBSRL_T_DATA     8'h00
`define IBSRL_T_EOF      8'h01
`define IBSRL_T_OSC      8'h02
`define IBSRL_T_MISC     8'h03
`define IBSRL_F_OLD      8'h01
`define IBSRL_F_CHIP     8'h07
`define IBSRL_F_BLK4K    8'h0C
`define IBSRL_BOOT_VEC   8'hFC
`define IBSRL_ERASED     8'hFF
`define IBSRL_ROM_BASE   16'hFC00
`define IBSRL_MC_FAST    4'h6
`define IBSRL_MC_SLOW    4'hC
`endif

// ==== src/ibsrl_pkg.sv ====
// Types shared by the loader and its serial engine
package ibsrl_pkg;
   typedef struct packed {
      logic        prog;
      logic        erase;
      logic        chip;
      logic [15:0] addr;
      logic [7:0]  data;
      logic [3:0]  block;
   } ibsrl_fl_req_t;
   typedef struct packed {
      logic        valid;
      logic        forced;
      logic        fx2;
      logic [15:0] start;
   } ibsrl_boot_t;
   typedef enum logic [2:0] {
      R_IDLE, R_MEAS, R_SKIP, R_WAIT, R_START, R_DATA, R_STOP
   } ibsrl_rx_st_t;
   typedef enum logic [2:0] {
      P_IDLE, P_HEX, P_EOL, P_EXEC, P_PROG, P_PWAIT, P_ERASE, P_EWAIT
   } ibsrl_p_st_t;
endpackage : ibsrl_pkg

// ==== src/ibsrl_uart.sv ====
// Autobaud serial receiver and transmitter
`timescale 1ns/100ps
module ibsrl_uart (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       rxd,
   input  wire logic       tx_start,
   input  wire logic [7:0] tx_data,
   output logic            txd,
   output logic            tx_busy,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            locked
);
   import ibsrl_pkg::*;
   `include "ibsrl_defs.svh"
   ibsrl_rx_st_t st;
   logic [15:0]  bit_len;
   logic [15:0]  cnt;
   logic [3:0]   bitn;
   logic [7:0]   sh;
   logic [9:0]   tsh;
   logic [15:0]  tcnt;
   logic [3:0]   tbits;

   // Low time of the start bit of the sync character is one bit time
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= R_IDLE; bit_len <= 16'h0000; cnt <= 16'h0000; bitn <= 4'h0;
         sh <= 8'h00; rx_valid <= 1'b0; rx_data <= 8'h00; locked <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         cnt <= cnt + 16'h0001;
         case (st)
            R_IDLE: if (!rxd) begin
               cnt <= 16'h0001;
               st <= R_MEAS;
            end
            R_MEAS: if (rxd) begin
               bit_len <= cnt;
               cnt <= 16'h0000;
               bitn <= 4'h0;
               st <= R_SKIP;
            end
            R_SKIP: if (cnt == bit_len - 16'h0001) begin
               cnt <= 16'h0000;
               bitn <= bitn + 4'h1;
               if (bitn == 4'h8) begin
                  locked <= 1'b1;
                  rx_valid <= 1'b1;
                  rx_data <= `IBSRL_CH_U;
                  st <= R_WAIT;
               end
            end
            R_WAIT: if (!rxd) begin
               cnt <= 16'h0000;
               st <= R_START;
            end
            R_START: if (cnt == {1'b0, bit_len[15:1]}) begin
               cnt <= 16'h0000;
               bitn <= 4'h0;
               st <= rxd ? R_WAIT : R_DATA;
            end
            R_DATA: if (cnt == bit_len - 16'h0001) begin
               cnt <= 16'h0000;
               sh <= {rxd, sh[7:1]};
               bitn <= bitn + 4'h1;
               if (bitn == 4'h7) st <= R_STOP;
            end
            R_STOP: if (cnt == bit_len - 16'h0001) begin
               rx_valid <= 1'b1;
               rx_data <= sh;
               st <= R_WAIT;
            end
            default: st <= R_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tsh <= 10'h3FF; tcnt <= 16'h0000; tbits <= 4'h0;
         txd <= 1'b1; tx_busy <= 1'b0;
      end else if (!tx_busy) begin
         if (tx_start) begin
            tsh <= {1'b1, tx_data, 1'b0};
            tbits <= 4'hA;
            tcnt <= 16'h0000;
            tx_busy <= 1'b1;
         end
      end else if (tcnt == 16'h0000) begin
         if (tbits == 4'h0) begin
            tx_busy <= 1'b0;
         end else begin
            txd <= tsh[0];
            tsh <= {1'b1, tsh[9:1]};
            tbits <= tbits - 4'h1;
            tcnt <= bit_len - 16'h0001;
         end
      end else begin
         tcnt <= tcnt - 16'h0001;
      end
   end
endmodule : ibsrl_uart

// ==== testbench/ibsrl_loader_properties.sv ====
// Checker for the boot select and record loader
`timescale 1ns/100ps
module ibsrl_loader_checker (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic [7:0]            status_byte,
   input wire logic [7:0]            boot_vector,
   input wire logic [2:0]            sec_bits,
   input ibsrl_pkg::ibsrl_fl_req_t   fl_req,
   input ibsrl_pkg::ibsrl_boot_t     boot,
   input wire logic [15:0]           fetch_addr,
   input wire logic                  rom_sel,
   input wire logic [9:0]            rom_addr,
   input wire logic                  mc_tick,
   input wire logic                  par_rd_lock,
   input wire logic                  par_wr_lock
);
   import ibsrl_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [7:0] vec;
   logic [4:0] gap;
   // An erased vector falls back to the factory loader page
   assign vec = (boot_vector == 8'hFF) ? 8'hFC : boot_vector;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) gap <= 5'h00;
      else gap <= mc_tick ? 5'h00 : gap + 5'h01;
   end
   a_boot_start: assert property (boot.valid |-> boot.start ==
      ((status_byte == 8'h00 && !boot.forced) ? 16'h0000 : {vec, 8'h00}))
      else $error("wrong start address");
   a_boot_hold: assert property (boot.valid |=> $stable(boot))
      else $error("boot decision changed");
   a_rom_map: assert property (rom_sel |-> $past(fetch_addr[15:10]) == 6'h3F
      && rom_addr == $past(fetch_addr[9:0])) else $error("rom overlay mismatch");
   a_rom_out: assert property ($past(fetch_addr[15:10]) != 6'h3F |-> !rom_sel)
      else $error("rom selected outside top page");
   a_tick_min: assert property (mc_tick |=> !mc_tick [*5]) else $error("tick too soon");
   a_tick_fast: assert property (boot.valid && boot.fx2 && mc_tick |-> ##6 mc_tick)
      else $error("fast mode tick late");
   a_tick_max: assert property (gap <= 5'h0C) else $error("tick too late");
   a_rd_lock: assert property ($past(resetn) |->
      par_rd_lock == $past(sec_bits[1] | sec_bits[2])) else $error("read lock wrong");
   a_wr_lock: assert property ($past(resetn) |-> par_wr_lock == |$past(sec_bits))
      else $error("write lock wrong");
   c_forced: cover property (boot.valid && boot.forced);
   c_prog: cover property (fl_req.prog);
   c_rom: cover property (rom_sel);
endmodule : ibsrl_loader_checker
bind ibsrl_loader ibsrl_loader_checker i_chk (.clk(clk), .resetn(resetn),
   .status_byte(status_byte), .boot_vector(boot_vector), .sec_bits(sec_bits),
   .fl_req(fl_req), .boot(boot), .fetch_addr(fetch_addr), .rom_sel(rom_sel),
   .rom_addr(rom_addr), .mc_tick(mc_tick), .par_rd_lock(par_rd_lock),
   .par_wr_lock(par_wr_lock));

// ==== testbench/ibsrl_host.sv ====
// Host programming station model on the serial link
`timescale 1ns/100ps
module ibsrl_host #(
   parameter int BIT = 16
) (
   input  wire logic clk,
   output logic      rxd,
   input  wire logic txd
);
   logic [7:0] rxq[$];
   logic [7:0] c;
   initial rxd = 1'b1;
   // 8N1 frame, start bit first, so the start low time gives the bit time
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT) @(posedge clk);
      end
   endtask : send
   // Samples mid-bit; a one-clock error in the measured bit time moves the last sample out of data bit 7
   always begin
      @(negedge txd);
      repeat (BIT + BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         c[i] = txd;
         repeat (BIT) @(posedge clk);
      end
      rxq.push_back(c);
   end
endmodule : ibsrl_host

// ==== testbench/ibsrl_loader_tb.sv ====
// Self-checking bench for the boot select and record loader
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module ibsrl_loader_tb;
   import ibsrl_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic pstr_n = 1'b1, ext = 1'b0, ale = 1'b0, fx2 = 1'b0, ok = 1'b1, fl_done = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] fetch_addr = 16'h0000;
   logic [7:0] sb = 8'h00, bv = 8'hFF;
   logic pready, pslverr, rxd, txd, rom_sel, mc_tick, rdl, wrl, er;
   logic [9:0] rom_addr;
   ibsrl_fl_req_t fl_req;
   ibsrl_boot_t boot;
   int bad_count = 0, n_compared = 0, n_prog = 0, n_erase = 0, n_chip = 0, n;
   always #25 clk = ~clk;
   ibsrl_loader i_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .program_store_strobe_n(pstr_n),
      .external_access_pin(ext), .addr_latch_pin(ale), .status_byte(sb),
      .boot_vector(bv), .flash_clock_double_bit(fx2), .sec_bits(3'b010),
      .fl_req(fl_req), .fl_done(fl_done), .fl_ok(ok), .boot(boot),
      .fetch_addr(fetch_addr), .rom_sel(rom_sel), .rom_addr(rom_addr),
      .mc_tick(mc_tick), .par_rd_lock(rdl), .par_wr_lock(wrl));
   ibsrl_host #(.BIT(16)) i_host (.clk(clk), .rxd(rxd), .txd(txd));
   // Flash answers every operation one cycle later
   always @(posedge clk) begin
      fl_done <= fl_req.prog | fl_req.erase | fl_req.chip;
      n_prog <= n_prog + int'(fl_req.prog);
      n_erase <= n_erase + int'(fl_req.erase);
      n_chip <= n_chip + int'(fl_req.chip);
   end
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready) break;
         if (i == 19) begin bad_count++; results(); end
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic restart();
      resetn <= 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      for (int i = 0; i < 20 && !boot.valid; i++) @(posedge clk);
      if (!boot.valid) begin bad_count++; results(); end
   endtask : restart
   task automatic tick();
      n = 0;
      for (int i = 0; i < 40; i++) begin @(posedge clk); if (mc_tick) break; end
      do begin @(posedge clk); n++; end while (!mc_tick && n < 40);
      if (!mc_tick) begin bad_count++; results(); end
   endtask : tick
   // Sends one record with line end and checks echoes then the reply
   task automatic rec(input string s, input string r);
      string t, e;
      t = (s == "U") ? s : {s, "\015\012"};
      e = {t, r};
      i_host.rxq.delete();
      foreach (t[i]) i_host.send(t[i]);
      for (int i = 0; i < 1000 && i_host.rxq.size() < e.len(); i++) @(posedge clk);
      if (i_host.rxq.size() < e.len()) begin bad_count++; results(); end
      foreach (e[i]) `CHK(i_host.rxq[i], e[i])
   endtask : rec
   initial begin
      #5ms bad_count++;
      results();
   end
   initial begin
      restart();
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[23:0], 24'h410000)
      `CHK({rdl, wrl}, 2'b11)
      apb(1'b0, 12'h000, 32'h0);
      `CHK(rd, 32'h00000002)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      fetch_addr <= 16'hFC05;
      repeat (2) @(posedge clk);
      `CHK({rom_sel, rom_addr}, 11'h405)
      tick();
      `CHK(n, 12)
      apb(1'b1, 12'h000, 32'h00000001);
      tick();
      tick();
      `CHK(n, 6)
      `CHK(rom_sel, 1'b0)
      rec("U", "");
      rec(":00000001FF", ".");
      rec(":00000001FE", "X");
      rec(":11", "X");
      rec(":0100000214E9", ".");
      rec(":02001000ABCD76", ".");
      `CHK({n_prog, fl_req.addr, fl_req.data}, {32'd2, 16'h0011, 8'hCD})
      rec(":02003000ABCD57", "X");
      `CHK(n_prog, 2)
      ok <= 1'b0;
      rec(":02002000ABCD66", "R");
      ok <= 1'b1;
      rec(":020000030C20CF", ".");
      `CHK({n_erase, fl_req.block}, {32'd1, 4'h2})
      rec(":020000030120DA", ".");
      `CHK({n_erase, fl_req.block}, {32'd3, 4'h3})
      rec(":0100000307F5", ".");
      `CHK(n_chip, 1)
      bv <= 8'hFC;
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, 32'h0014032E)
      fx2 <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[20:18], 3'b010)
      pstr_n <= 1'b0;
      ext <= 1'b1;
      ale <= 1'b1;
      restart();
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[18:0], 19'h7FC00)
      sb <= 8'h01;
      bv <= 8'h12;
      restart();
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd[18:0], 19'h71200)
      results();
   end
endmodule : ibsrl_loader_tb
